// ### osc_ctrl_pkg.sv
// Shared constants for the oscillator control and switch block
`default_nettype none
package osc_ctrl_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_IRQ_STAT = 4'h4;
  localparam logic [3:0] OFS_IRQ_MASK = 4'h8;
  // ==========================================================
  // Control word fields
  localparam int BIT_SW_REQ = 0;
  localparam int BIT_SECONDARY_OSCILLATOR_EN = 1;
  localparam int BIT_DRIVE = 2;
  localparam int BIT_FAIL = 3;
  localparam int BIT_UNUSED4 = 4;
  localparam int BIT_PLL_LOCK = 5;
  localparam int BIT_UNUSED6 = 6;
  localparam int BIT_SEL_LOCK = 7;
  localparam int NEXT_LSB = 8;
  localparam int CUR_LSB = 12;
  localparam int SRC_W = 3;
  localparam logic [7:0] LOW_BYTE_RST = 8'h00;
  // ==========================================================
  // Unlock keys, high byte then low byte
  localparam logic [7:0] KEY_HI_1 = 8'h78;
  localparam logic [7:0] KEY_HI_2 = 8'h9A;
  localparam logic [7:0] KEY_LO_1 = 8'h46;
  localparam logic [7:0] KEY_LO_2 = 8'h57;
  // ==========================================================
  // Interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAIL = 1;
  localparam int IRQ_W = 2;
  localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;
  // ==========================================================
  // Bus responses and source map
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] PLL_SRC_MASK_DEF = 8'h0A;
endpackage : osc_ctrl_pkg
`default_nettype wire

// ### osc_key_unlock.sv
// Two-key unlock gate for one protected byte
`default_nettype none
module osc_key_unlock
  import osc_ctrl_pkg::*;
#(
  parameter logic [7:0] KEY_1 = KEY_LO_1,
  parameter logic [7:0] KEY_2 = KEY_LO_2
)(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic wr_i,
  input wire logic lane_i,
  input wire logic [7:0] data_i,
  output logic allow_o
);
  typedef enum logic [1:0] {IDLE, GOT_FIRST, ARMED} key_st_t;
  key_st_t state_q;

  if (KEY_1 == KEY_2)
  begin : g_bad_keys
    $error("Unlock keys must differ");
  end

  // Only the write right after the pair may land
  assign allow_o = wr_i && lane_i && (state_q == ARMED);

  // ==========================================================
  // Key sequencer
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      state_q <= IDLE;
    else if (ce_i && wr_i)
    begin
      if (state_q == ARMED)
        state_q <= IDLE;
      else if (lane_i && data_i == KEY_1 && state_q == IDLE)
        state_q <= GOT_FIRST;
      else if (lane_i && data_i == KEY_2 && state_q == GOT_FIRST)
        state_q <= ARMED;
      else
        state_q <= IDLE;
    end
  end

  chk_key_order: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    $rose(state_q == ARMED) |->
      $past(lane_i) && $past(data_i) == KEY_2)
    else $error("armed without second key");
  chk_stray_voids: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    (ce_i && wr_i && !(lane_i && (data_i == KEY_1 ||
      data_i == KEY_2))) |=> state_q == IDLE)
    else $error("stray write kept unlock state");
  cov_armed: cover property (@(posedge clk_i)
    disable iff (!rst_n_i) allow_o);
endmodule : osc_key_unlock
`default_nettype wire

// ### osc_switch_seq.sv
// Clock switch sequencer: waits for the new source to settle
`default_nettype none
module osc_switch_seq (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic start_i,
  input wire logic ready_i,
  output logic busy_o,
  output logic done_o
);
  typedef enum logic {SEQ_IDLE, SEQ_WAIT} seq_st_t;
  seq_st_t state_q;

  // ==========================================================
  // Switch progress
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= SEQ_IDLE;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end
    else if (ce_i)
    begin
      done_o <= 1'b0;
      case (state_q)
        SEQ_IDLE:
          if (start_i)
          begin
            state_q <= SEQ_WAIT;
            busy_o <= 1'b1;
          end
        SEQ_WAIT:
          if (ready_i)
          begin
            state_q <= SEQ_IDLE;
            busy_o <= 1'b0;
            done_o <= 1'b1;
          end
        default:
          state_q <= SEQ_IDLE;
      endcase
    end
  end

  chk_done_needs_ready: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    $rose(done_o) |-> $past(ready_i) && $past(busy_o) && !busy_o)
    else $error("switch finished without ready source");
endmodule : osc_switch_seq
`default_nettype wire

// ### osc_ctrl_switch.sv
// Oscillator control register, unlock and switch logic
// ==========================================================
`default_nettype none
module osc_ctrl_switch
  import osc_ctrl_pkg::*;
#(
  parameter int ADDR_W = 4,
  parameter logic [7:0] PLL_SRC_MASK = PLL_SRC_MASK_DEF
)(
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  input wire logic [ADDR_W-1:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic [ADDR_W-1:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I,
  input wire logic FAILSAFE_CFG_I,
  input wire logic SECONDARY_OSCILLATOR_SRC_CFG_I,
  input wire logic SECONDARY_OSCILLATOR_HP_CFG_I,
  input wire logic [SRC_W-1:0] INIT_SRC_CFG_I,
  input wire logic PLL_LOCKED_I,
  input wire logic PLL_TIMER_DONE_I,
  input wire logic SRC_READY_I,
  input wire logic CLK_FAIL_I,
  output logic [SRC_W-1:0] CUR_SOURCE_O,
  output logic SECONDARY_OSCILLATOR_EN_O,
  output logic SECONDARY_OSCILLATOR_HIGH_POWER_O,
  output logic IRQ_O
);
  if (ADDR_W < 4 || ADDR_W > 16)
  begin : g_bad_addr
    $error("ADDR_W must be 4 to 16");
  end
  // ==========================================================
  // Decode helpers
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [3:0] ofs);
    hit = ((a >> 2) == (ADDR_W'(ofs) >> 2));
  endfunction : hit
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = hit(a, OFS_CTRL) || hit(a, OFS_IRQ_STAT) ||
             hit(a, OFS_IRQ_MASK);
  endfunction : mapped
  logic aw_rdy_q, w_rdy_q, ar_rdy_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic do_wr, ctrl_wr, hi_allow, lo_allow;
  logic sel_lock_q, pll_lock_q, fail_q, drive_q, sw_req_q;
  logic [SRC_W-1:0] next_src_q, tgt_src_q;
  logic [IRQ_W-1:0] stat_q, mask_q, stat_set;
  logic permit, seq_start, seq_busy, seq_done, fail_evt;
  logic [31:0] ctrl_word;
  // ==========================================================
  // AXI4-Lite write channel
  // Address and data are caught independently, so either order works
  assign do_wr = !aw_rdy_q && !w_rdy_q && !BVALID_O;
  assign ctrl_wr = do_wr && hit(aw_addr_q, OFS_CTRL);
  always_ff @(posedge MCLK_I)
  begin
    if (!RST_N_I)
    begin
      aw_rdy_q <= 1'b1;
      w_rdy_q <= 1'b1;
      aw_addr_q <= '0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      BVALID_O <= 1'b0;
      BRESP_O <= RESP_OKAY;
    end
    else if (CE_I)
    begin
      if (AWVALID_I && aw_rdy_q)
      begin
        aw_rdy_q <= 1'b0;
        aw_addr_q <= AWADDR_I;
      end
      else if (do_wr)
        aw_rdy_q <= 1'b1;
      if (WVALID_I && w_rdy_q)
      begin
        w_rdy_q <= 1'b0;
        w_data_q <= WDATA_I;
        w_strb_q <= WSTRB_I;
      end
      else if (do_wr)
        w_rdy_q <= 1'b1;
      if (do_wr)
      begin
        BVALID_O <= 1'b1;
        BRESP_O <= mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (BREADY_I)
        BVALID_O <= 1'b0;
    end
  end

  assign AWREADY_O = aw_rdy_q;
  assign WREADY_O = w_rdy_q;
  // ==========================================================
  // Unlock gates for both control bytes
  // Any bus write counts as an instruction and breaks a key pair
  osc_key_unlock #(
    .KEY_1(KEY_HI_1),
    .KEY_2(KEY_HI_2)
  ) u_unlock_hi (
    .clk_i(MCLK_I),
    .rst_n_i(RST_N_I),
    .ce_i(CE_I),
    .wr_i(do_wr),
    .lane_i(ctrl_wr && w_strb_q[1]),
    .data_i(w_data_q[15:8]),
    .allow_o(hi_allow)
  );
  osc_key_unlock #(
    .KEY_1(KEY_LO_1),
    .KEY_2(KEY_LO_2)
  ) u_unlock_lo (
    .clk_i(MCLK_I),
    .rst_n_i(RST_N_I),
    .ce_i(CE_I),
    .wr_i(do_wr),
    .lane_i(ctrl_wr && w_strb_q[0]),
    .data_i(w_data_q[7:0]),
    .allow_o(lo_allow)
  );
  // ==========================================================
  // Selection lock and switch sequencing
  assign permit = !(FAILSAFE_CFG_I && sel_lock_q);
  // Done cycle still shows the old request; no second switch from it
  assign seq_start = sw_req_q && permit && !seq_busy && !seq_done;
  osc_switch_seq u_seq (
    .clk_i(MCLK_I),
    .rst_n_i(RST_N_I),
    .ce_i(CE_I),
    .start_i(seq_start),
    .ready_i(SRC_READY_I),
    .busy_o(seq_busy),
    .done_o(seq_done)
  );
  // Source fields; initial source caught at reset from configuration
  always_ff @(posedge MCLK_I)
  begin
    if (!RST_N_I)
    begin
      next_src_q <= INIT_SRC_CFG_I;
      tgt_src_q <= INIT_SRC_CFG_I;
      CUR_SOURCE_O <= INIT_SRC_CFG_I;
    end
    else if (CE_I)
    begin
      if (hi_allow && permit)
        next_src_q <= w_data_q[NEXT_LSB +: SRC_W];
      if (seq_start)
        tgt_src_q <= next_src_q;
      if (seq_done)
        CUR_SOURCE_O <= tgt_src_q;
    end
  end

  // ==========================================================
  // Low control byte
  // Bits 6 and 4 have no storage at all
  always_ff @(posedge MCLK_I)
  begin
    if (!RST_N_I)
    begin
      sel_lock_q <= LOW_BYTE_RST[BIT_SEL_LOCK];
      drive_q <= LOW_BYTE_RST[BIT_DRIVE];
      SECONDARY_OSCILLATOR_EN_O <= LOW_BYTE_RST[BIT_SECONDARY_OSCILLATOR_EN];
      sw_req_q <= LOW_BYTE_RST[BIT_SW_REQ];
    end
    else if (CE_I)
    begin
      if (lo_allow)
      begin
        sel_lock_q <= w_data_q[BIT_SEL_LOCK];
        drive_q <= w_data_q[BIT_DRIVE];
        SECONDARY_OSCILLATOR_EN_O <= w_data_q[BIT_SECONDARY_OSCILLATOR_EN];
      end
      // Only hardware may drop a pending request
      if (seq_done)
        sw_req_q <= 1'b0;
      else if (lo_allow && w_data_q[BIT_SW_REQ])
        sw_req_q <= 1'b1;
    end
  end

  // Drive bit is moot for a digital clock input
  always_ff @(posedge MCLK_I)
  begin
    if (!RST_N_I)
      SECONDARY_OSCILLATOR_HIGH_POWER_O <= 1'b0;
    else if (CE_I)
      SECONDARY_OSCILLATOR_HIGH_POWER_O <= SECONDARY_OSCILLATOR_SRC_CFG_I &&
        (drive_q || SECONDARY_OSCILLATOR_HP_CFG_I);
  end

  // ==========================================================
  // Status flags
  assign fail_evt = CLK_FAIL_I && FAILSAFE_CFG_I;
  always_ff @(posedge MCLK_I)
  begin
    if (!RST_N_I)
      pll_lock_q <= 1'b0;
    else if (CE_I)
      pll_lock_q <= !seq_busy && PLL_SRC_MASK[CUR_SOURCE_O] &&
        (PLL_LOCKED_I || PLL_TIMER_DONE_I);
  end

  // Set wins over a software clear in the same cycle
  always_ff @(posedge MCLK_I)
  begin
    if (!RST_N_I)
      fail_q <= 1'b0;
    else if (CE_I)
    begin
      if (fail_evt)
        fail_q <= 1'b1;
      else if (lo_allow && !w_data_q[BIT_FAIL])
        fail_q <= 1'b0;
    end
  end

  // ==========================================================
  // Interrupt status, mask and output
  assign stat_set = {fail_evt, seq_done};
  always_ff @(posedge MCLK_I)
  begin
    if (!RST_N_I)
    begin
      stat_q <= IRQ_RST;
      mask_q <= IRQ_RST;
      IRQ_O <= 1'b0;
    end
    else if (CE_I)
    begin
      if (do_wr && hit(aw_addr_q, OFS_IRQ_STAT) && w_strb_q[0])
        stat_q <= (stat_q & ~w_data_q[IRQ_W-1:0]) | stat_set;
      else
        stat_q <= stat_q | stat_set;
      if (do_wr && hit(aw_addr_q, OFS_IRQ_MASK) && w_strb_q[0])
        mask_q <= w_data_q[IRQ_W-1:0];
      IRQ_O <= |(stat_q & mask_q);
    end
  end

  // ==========================================================
  // AXI4-Lite read channel, data one edge after the address
  always_comb
  begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[CUR_LSB +: SRC_W] = CUR_SOURCE_O;
    ctrl_word[NEXT_LSB +: SRC_W] = next_src_q;
    ctrl_word[BIT_SEL_LOCK] = sel_lock_q;
    ctrl_word[BIT_PLL_LOCK] = pll_lock_q;
    ctrl_word[BIT_FAIL] = fail_q;
    ctrl_word[BIT_DRIVE] = drive_q;
    ctrl_word[BIT_SECONDARY_OSCILLATOR_EN] = SECONDARY_OSCILLATOR_EN_O;
    ctrl_word[BIT_SW_REQ] = sw_req_q;
  end

  always_ff @(posedge MCLK_I)
  begin
    if (!RST_N_I)
    begin
      ar_rdy_q <= 1'b1;
      RVALID_O <= 1'b0;
      RDATA_O <= 32'h0000_0000;
      RRESP_O <= RESP_OKAY;
    end
    else if (CE_I)
    begin
      if (ARVALID_I && ar_rdy_q)
      begin
        ar_rdy_q <= 1'b0;
        RVALID_O <= 1'b1;
        RRESP_O <= RESP_OKAY;
        if (hit(ARADDR_I, OFS_CTRL))
          RDATA_O <= ctrl_word;
        else if (hit(ARADDR_I, OFS_IRQ_STAT))
          RDATA_O <= {30'h0000_0000, stat_q};
        else if (hit(ARADDR_I, OFS_IRQ_MASK))
          RDATA_O <= {30'h0000_0000, mask_q};
        else
        begin
          RDATA_O <= 32'h0000_0000;
          RRESP_O <= RESP_SLVERR;
        end
      end
      else if (RVALID_O && RREADY_I)
      begin
        RVALID_O <= 1'b0;
        ar_rdy_q <= 1'b1;
      end
    end
  end

  assign ARREADY_O = ar_rdy_q;
  // ==========================================================
  // Checks
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RST_N_I);
  chk_lock_freezes_src: assert property (
    (CE_I && FAILSAFE_CFG_I && sel_lock_q && !seq_busy)
      |=> $stable(CUR_SOURCE_O) && !seq_busy)
    else $error("locked selection still switched");
  chk_unlocked_switch: assert property (
    (CE_I && !FAILSAFE_CFG_I && sw_req_q && !seq_busy && !seq_done)
      |=> seq_busy)
    else $error("switch refused with monitor off");
  chk_unused_bits_zero: assert property (
    RVALID_O |-> !RDATA_O[BIT_UNUSED6] && !RDATA_O[BIT_UNUSED4])
    else $error("unimplemented control bit read as one");
  chk_pll_flag_cause: assert property (
    (pll_lock_q && $past(CE_I)) |->
      $past(PLL_LOCKED_I || PLL_TIMER_DONE_I))
    else $error("lock flag without lock or timer");
  chk_flag_clear_switch: assert property (
    (CE_I && seq_busy) |=> !pll_lock_q)
    else $error("lock flag set during switch");
  chk_fail_sets_flag: assert property (
    (CE_I && fail_evt) |=> fail_q ##1 (fail_q || $past(lo_allow)))
    else $error("clock failure not flagged");
  chk_drive_ignored: assert property (
    (SECONDARY_OSCILLATOR_HIGH_POWER_O && $past(CE_I)) |-> $past(SECONDARY_OSCILLATOR_SRC_CFG_I))
    else $error("drive active on digital clock input");
  chk_request_clears: assert property (
    (CE_I && seq_done) |=> !sw_req_q && CUR_SOURCE_O == $past(tgt_src_q))
    else $error("request not cleared after switch");

  cov_switch_done: cover property (seq_done);
  cov_clock_fail: cover property (fail_evt ##1 IRQ_O [*2]);
  cov_locked_refusal: cover property (
    (sw_req_q && !permit && !seq_busy) [*3]);
  cov_hi_write: cover property (hi_allow);
endmodule : osc_ctrl_switch
`default_nettype wire

// ### tb_osc_ctrl_switch.sv
// Register level testbench for the oscillator control and switch block
`default_nettype none
module tb_osc_ctrl_switch;
  import osc_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals
  localparam logic [2:0] INIT_SRC = 3'h2;
  logic mclk, rst_n, ce, awvalid, wvalid, arvalid, bready, rready;
  logic fs_cfg, src_cfg, hp_cfg, pll_locked, pll_timer, src_ready, clk_fail;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, rv;
  logic awready, wready, bvalid, arready, rvalid, irq, secondary_oscillator_en, secondary_oscillator_hp;
  logic [1:0] bresp, rresp, br, rr;
  logic [2:0] cur_src;
  int n_errors = 0;
  int total_checks = 0;
  osc_ctrl_switch osc_ctrl_switch_inst (
    .MCLK_I(mclk), .RST_N_I(rst_n), .CE_I(ce),
    .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready),
    .WDATA_I(wdata), .WSTRB_I(wstrb), .WVALID_I(wvalid), .WREADY_O(wready),
    .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
    .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready),
    .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready),
    .FAILSAFE_CFG_I(fs_cfg), .SECONDARY_OSCILLATOR_SRC_CFG_I(src_cfg),
    .SECONDARY_OSCILLATOR_HP_CFG_I(hp_cfg), .INIT_SRC_CFG_I(INIT_SRC),
    .PLL_LOCKED_I(pll_locked), .PLL_TIMER_DONE_I(pll_timer),
    .SRC_READY_I(src_ready), .CLK_FAIL_I(clk_fail),
    .CUR_SOURCE_O(cur_src), .SECONDARY_OSCILLATOR_EN_O(secondary_oscillator_en),
    .SECONDARY_OSCILLATOR_HIGH_POWER_O(secondary_oscillator_hp), .IRQ_O(irq)
  );
  // ==========================================================
  // Bus tasks
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge mclk);
      if (!aw_ok && awready === 1'b1)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    // Bready stays high, so the answer is taken at the edge it is seen
    do @(posedge mclk); while (bvalid !== 1'b1);
    br = bresp;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    rv = rdata;
    rr = rresp;
  endtask : rd
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic lo_key();
    wr(OFS_CTRL, {24'h0, KEY_LO_1}, 4'h1);
    wr(OFS_CTRL, {24'h0, KEY_LO_2}, 4'h1);
  endtask : lo_key
  task automatic hi_key();
    wr(OFS_CTRL, {16'h0, KEY_HI_1, 8'h00}, 4'h2);
    wr(OFS_CTRL, {16'h0, KEY_HI_2, 8'h00}, 4'h2);
  endtask : hi_key
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  // ==========================================================
  // Clock and watchdog
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial
  begin
    // Whole sequence needs well under two thousand cycles
    repeat (20000) @(posedge mclk);
    n_errors++;
    complete_run();
  end
  // ==========================================================
  // Tests
  initial
  begin
    {rst_n, awvalid, wvalid, arvalid, clk_fail, fs_cfg, src_ready} = '0;
    {ce, bready, rready, src_cfg, pll_locked} = 5'h1F;
    {hp_cfg, pll_timer, awaddr, araddr, wstrb, wdata} = '0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    rd(OFS_CTRL);
    check("ctrl reset", rv, {17'h0, INIT_SRC, 1'b0, INIT_SRC, 8'h00});
    rd(OFS_IRQ_STAT);
    check("status reset", rv, 32'h0);
    check("secondary_oscillator en reset", {31'h0, secondary_oscillator_en}, 32'h0);
    wr(4'hC, 32'h0000FFFF, 4'h3);
    check("bresp unmapped", {30'h0, br}, {30'h0, RESP_SLVERR});
    rd(4'hC);
    check("rresp unmapped", {30'h0, rr}, {30'h0, RESP_SLVERR});
    check("rdata unmapped", rv, 32'h0);
    wr(OFS_CTRL, 32'h00000006, 4'h1);
    rd(OFS_CTRL);
    check("low no key", {24'h0, rv[7:0]}, 32'h0);
    lo_key();
    wr(OFS_CTRL, 32'h00000056, 4'h1);
    rd(OFS_CTRL);
    check("low keyed", {24'h0, rv[7:0]}, 32'h06);
    // Drive and enable against every configuration pairing
    for (int i = 0; i < 8; i++)
    begin
      src_cfg <= i[1];
      hp_cfg <= i[2];
      lo_key();
      wr(OFS_CTRL, {29'h0, i[0], i[1] ^ i[2], 1'b0}, 4'h1);
      repeat (2) @(posedge mclk);
      check("secondary_oscillator en", {31'h0, secondary_oscillator_en}, {31'h0, i[1] ^ i[2]});
      check("high power", {31'h0, secondary_oscillator_hp},
            {31'h0, i[1] & (i[0] | i[2])});
    end
    // Broken key runs must leave the byte at 04h
    wr(OFS_CTRL, {24'h0, KEY_LO_1}, 4'h1);
    lo_key();
    wr(OFS_CTRL, 32'h00000002, 4'h1);
    lo_key();
    wr(OFS_IRQ_MASK, 32'h0, 4'hF);
    wr(OFS_CTRL, 32'h00000002, 4'h1);
    rd(OFS_CTRL);
    check("low after bad keys", {24'h0, rv[7:0]}, 32'h04);
    wr(OFS_CTRL, 32'h00000500, 4'h2);
    hi_key();
    wr(OFS_CTRL, 32'h00000300, 4'h2);
    rd(OFS_CTRL);
    check("next source", {29'h0, rv[10:8]}, 32'h3);
    // Monitor off: a set selection lock must not block the switch
    lo_key();
    wr(OFS_CTRL, 32'h00000081, 4'h1);
    rd(OFS_CTRL);
    check("request pending", {30'h0, rv[5], rv[0]}, 32'h1);
    check("cur before done", {29'h0, cur_src}, {29'h0, INIT_SRC});
    src_ready <= 1'b1;
    for (int k = 0; k < 20; k++)
    begin
      rd(OFS_CTRL);
      if (rv[0] === 1'b0)
        break;
    end
    src_ready <= 1'b0;
    check("request cleared", {31'h0, rv[0]}, 32'h0);
    check("cur after done", {29'h0, cur_src}, 32'h3);
    // Source 3 uses the PLL; lock or timer alone sets the flag
    for (int j = 0; j < 3; j++)
    begin
      pll_locked <= (j == 0);
      pll_timer <= (j == 1);
      repeat (3) @(posedge mclk);
      rd(OFS_CTRL);
      check("pll lock flag", {31'h0, rv[5]}, {31'h0, j != 2});
    end
    rd(OFS_IRQ_STAT);
    check("done status", rv, 32'h1);
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(OFS_IRQ_MASK, 32'h3, 4'hF);
    repeat (3) @(posedge mclk);
    check("irq done", {31'h0, irq}, 32'h1);
    wr(OFS_IRQ_STAT, 32'h1, 4'hF);
    repeat (3) @(posedge mclk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    // Monitor on with lock set: source and switch stay frozen
    fs_cfg <= 1'b1;
    hi_key();
    wr(OFS_CTRL, 32'h00000100, 4'h2);
    src_ready <= 1'b1;
    lo_key();
    wr(OFS_CTRL, 32'h00000081, 4'h1);
    repeat (10) @(posedge mclk);
    rd(OFS_CTRL);
    check("locked next", {29'h0, rv[10:8]}, 32'h3);
    check("locked request", {31'h0, rv[0]}, 32'h1);
    check("locked lock flag", {31'h0, rv[5]}, 32'h0);
    check("locked cur", {29'h0, cur_src}, 32'h3);
    check("fail flag idle", {31'h0, rv[3]}, 32'h0);
    clk_fail <= 1'b1;
    @(posedge mclk);
    clk_fail <= 1'b0;
    repeat (3) @(posedge mclk);
    rd(OFS_CTRL);
    check("fail flag set", {31'h0, rv[3]}, 32'h1);
    rd(OFS_IRQ_STAT);
    check("fail status", rv, 32'h2);
    check("irq fail", {31'h0, irq}, 32'h1);
    complete_run();
  end
endmodule : tb_osc_ctrl_switch
`default_nettype wire
